// file: hw/rfdb_defines.svh
// Constants for the receive framer, decoder and self-test checker
`ifndef RFDB_DEFINES_SVH
`define RFDB_DEFINES_SVH
// Register byte offsets
`define RFDB_OFS_CTRL      8'h00
`define RFDB_OFS_BIST      8'h04
`define RFDB_OFS_STATUS    8'h08
// Control register fields
`define RFDB_CTRL_FR_EN    0
`define RFDB_CTRL_FMODE    2:1
`define RFDB_CTRL_FCHAR    4:3
`define RFDB_CTRL_DMODE    6:5
`define RFDB_CTRL_CKSEL    8:7
`define RFDB_CTRL_RATE     9
`define RFDB_CTRL_RST      10'h0aa
// Self-test register fields
`define RFDB_BIST_LE       0
`define RFDB_BIST_CHEN     1
`define RFDB_BIST_LATCH    2
`define RFDB_BIST_RST      2'h2
// Three-level codes
`define RFDB_LVL_LOW       2'h0
`define RFDB_LVL_MID       2'h1
`define RFDB_LVL_HIGH      2'h2
// Framer constants
`define RFDB_CHAR_LAST     4'h9
`define RFDB_MAX_STRETCH   4'h2
`define RFDB_SPAN_BITS     6'h32
`define RFDB_CONSEC_GAP    6'h09
`define RFDB_CONSEC_NEED   3'h4
`define RFDB_COMMA_P       8'h3e
`define RFDB_COMMA_N       8'hc1
`define RFDB_K285_P        10'h0fa
`define RFDB_K285_N        10'h305
// Decoder and status codes
`define RFDB_ALT_K_XOR     8'h80
`define RFDB_ST_DATA       3'h0
`define RFDB_ST_SPECIAL    3'h1
`define RFDB_ST_FRAMING    3'h2
`define RFDB_ST_INVALID    3'h6
`define RFDB_ST_LOOP_OK    3'h2
`define RFDB_ST_LOOP_ERR   3'h4
`define RFDB_ST_MISMATCH   3'h5
`define RFDB_ST_WAIT       3'h7
// Self-test constants
`define RFDB_START_CHAR    10'h274
`define RFDB_LFSR_SEED     9'h1ff
`define RFDB_WSYNC_LEN     5'h10
`define RFDB_ABORT_BAL     5'h10
`endif

// file: hw/rfdb_pkg.sv
// Types shared by the receive framer, decoder and self-test block
package rfdb_pkg;
    typedef enum logic [1:0]
    {
        RFDB_B_OFF    = 2'b00,
        RFDB_B_SEARCH = 2'b01,
        RFDB_B_RUN    = 2'b10
    } rfdb_bist_t;

    typedef struct packed
    {
        logic [9:0] data;
        logic [2:0] status;
        logic       parity;
    } rfdb_char_t;
endpackage

// file: hw/rfdb_top.sv
// Receive framer, 10b/8b decoder and self-test checker for one channel
//
// Functional notes
// [RULE1] Framer disabled: boundaries never move whatever framing characters arrive.
// [RULE2] Framer enabled: the selected framing algorithm runs on every channel at once.
// [RULE3] Low-latency mode aligns from the first framing character by stretching characters.
// [RULE4] One character is stretched by at most two bit periods.
// [RULE5] Aligned output lags detection by at most nine or fourteen characters.
// [RULE6] Mid mode moves boundary after two same-phase framing characters within 50 bits.
// [RULE7] High mode moves boundary after four consecutive same-phase framing characters.
// [RULE8] Software must not use low-latency framing while self-test is active.
// [RULE9] Decoded data reports status 000, special characters 001.
// [RULE10] Decoder bypass passes raw 10-bit characters; clock select must be mid.
// [RULE11] Special codes use primary mapping at mid, alternate mapping at high.
// [RULE12] Every delivered character carries odd parity.
// [RULE13] Latch enable high passes channel enable; falling edge holds it.
// [RULE14] Reset forces the self-test enable latch high, test disabled.
// [RULE15] Self-test uses a shift register producing a 511-character sequence.
// [RULE16] Clock select not mid: 16 word-sync characters precede each pass.
// [RULE17] Self-test start presets the shift register to start code D0.0.
// [RULE18] Synchronised checker compares each character and reports on status.
// [RULE19] Expected violations are not errors; loop end shows 010 or 100 once.
// [RULE20] Self-test status is the same in every decoder mode.
// [RULE21] Invalid exceeding valid by sixteen aborts and restarts the search.
// [RULE22] Software frames before self-test with alternate framer and recovered clock.
// [RULE23] Framer searches every bit for comma or full K28.5 as selected.
// [RULE24] Three-level inputs are two-bit codes, static while framing.
// [RULE25] Realignment emits no partial character; that character reports invalid.
`include "rfdb_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module rfdb_top
    import rfdb_pkg::*;
#(
    parameter int CHAR_BITS = 10
)
(
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_link_clk,
    input  wire logic        i_rx_bit,
    input  wire logic        i_hsel,
    input  wire logic [1:0]  i_htrans,
    input  wire logic [7:0]  i_haddr,
    input  wire logic        i_hwrite,
    input  wire logic [2:0]  i_hsize,
    input  wire logic        i_hready,
    input  wire logic [31:0] i_hwdata,
    output logic      [31:0] o_hrdata,
    output logic             o_hreadyout,
    output logic             o_hresp,
    output logic      [9:0]  o_rx_char,
    output logic      [2:0]  o_rx_status,
    output logic             o_rx_parity,
    output logic             o_char_strobe
);
    generate
        if (CHAR_BITS != 10)
            $error("rfdb_top serves 10-bit characters only");
    endgenerate

    // ==========================================================
    // Register bus slave, zero wait states
    logic [9:0] ctrl_q;
    logic [1:0] bist_reg_q;
    logic [7:0] addr_q;
    logic       wr_q;
    logic       bist_n_q;
    rfdb_char_t out_q;
    rfdb_bist_t bst_q;

    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
        begin
            addr_q <= 8'h00;
            wr_q   <= 1'b0;
        end
        else if (i_hready)
        begin
            addr_q <= i_haddr;
            wr_q   <= i_hsel && i_htrans[1] && i_hwrite && (i_hsize == 3'h2);
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
            ctrl_q <= `RFDB_CTRL_RST;
        else if (wr_q && addr_q == `RFDB_OFS_CTRL)
            ctrl_q <= i_hwdata[9:0];
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
            bist_reg_q <= `RFDB_BIST_RST;
        else if (wr_q && addr_q == `RFDB_OFS_BIST)
            bist_reg_q <= i_hwdata[1:0];
    end

    always_comb
    begin
        case (addr_q)
            `RFDB_OFS_CTRL:   o_hrdata = {22'h0, ctrl_q};
            `RFDB_OFS_BIST:   o_hrdata = {29'h0, bist_n_q, bist_reg_q};
            `RFDB_OFS_STATUS: o_hrdata = {16'h0, bst_q, out_q};
            default:          o_hrdata = 32'h0;
        endcase
    end
    assign o_hreadyout = 1'b1;
    assign o_hresp     = 1'b0;

    // Unused encodings 2'b11 fall back to mid
    function automatic logic [1:0] lvl(input logic [1:0] v);
        lvl = (v == 2'h3) ? `RFDB_LVL_MID : v;
    endfunction

    // [RULE24] Two-bit three-level codes
    logic [1:0] fmode, fchar, dmode, cksel;
    logic       fr_en;
    assign fr_en = ctrl_q[`RFDB_CTRL_FR_EN];
    assign fmode = lvl(ctrl_q[`RFDB_CTRL_FMODE]);
    assign fchar = lvl(ctrl_q[`RFDB_CTRL_FCHAR]);
    assign dmode = lvl(ctrl_q[`RFDB_CTRL_DMODE]);
    assign cksel = lvl(ctrl_q[`RFDB_CTRL_CKSEL]);

    // ==========================================================
    // Link input synchronisers and bit edge detect
    logic [1:0] lck_s, bit_s;
    logic       lck_d_q, tick;
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
        begin
            lck_s   <= 2'h0;
            bit_s   <= 2'h0;
            lck_d_q <= 1'b0;
        end
        else
        begin
            lck_s   <= {lck_s[0], i_link_clk};
            bit_s   <= {bit_s[0], i_rx_bit};
            lck_d_q <= lck_s[1];
        end
    end
    assign tick = lck_s[1] && !lck_d_q;

    // ==========================================================
    // Framer
    logic [9:0] sh_q, sh_n;
    logic [3:0] cnt_q, last_q, pend_q, phase_q, step;
    logic [5:0] age_q;
    logic [2:0] cons_q;
    logic       seen_q, det, at_bnd, realign, emit;

    assign sh_n   = {sh_q[8:0], bit_s[1]};
    assign at_bnd = (cnt_q == last_q);
    assign step   = (pend_q > `RFDB_MAX_STRETCH) ? `RFDB_MAX_STRETCH : pend_q;

    // [RULE23] Search every bit position
    always_comb
    begin
        if (fchar == `RFDB_LVL_HIGH)
            det = (sh_n == `RFDB_K285_P) || (sh_n == `RFDB_K285_N);
        else
            det = (sh_n[9:2] == `RFDB_COMMA_P) || (sh_n[9:2] == `RFDB_COMMA_N);
    end

    // [RULE6] [RULE7] Multi-byte confirmation before a boundary move
    always_comb
    begin
        realign = 1'b0;
        if (tick && fr_en && det && !at_bnd && seen_q && phase_q == cnt_q)
        begin
            if (fmode == `RFDB_LVL_MID)
                realign = (age_q < `RFDB_SPAN_BITS);
            else if (fmode == `RFDB_LVL_HIGH)
                realign = (age_q == `RFDB_CONSEC_GAP) && (cons_q + 3'h1 >= `RFDB_CONSEC_NEED);
        end
    end
    // [RULE25] Realignment completes the character now, never mid-character
    assign emit = tick && (at_bnd || realign);

    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
            sh_q <= 10'h0;
        else if (tick)
            sh_q <= sh_n;
    end

    // [RULE1] [RULE2] Counter moves freely unless the enabled framer realigns or stretches it
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
        begin
            cnt_q  <= 4'h0;
            last_q <= `RFDB_CHAR_LAST;
            pend_q <= 4'h0;
        end
        else if (tick)
        begin
            if (emit)
            begin
                cnt_q <= 4'h0;
                // [RULE4] Stretch at most two bits per character
                last_q <= `RFDB_CHAR_LAST + step;
                pend_q <= pend_q - step;
            end
            else
                cnt_q <= cnt_q + 4'h1;
            // [RULE3] [RULE5] Low latency starts on the first detection
            if (fr_en && fmode == `RFDB_LVL_LOW && det && !at_bnd && pend_q == 4'h0
                && last_q == `RFDB_CHAR_LAST)
                pend_q <= cnt_q + 4'h1;
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
        begin
            age_q   <= 6'h0;
            seen_q  <= 1'b0;
            phase_q <= 4'h0;
            cons_q  <= 3'h0;
        end
        else if (tick)
        begin
            if (det && fr_en)
            begin
                age_q   <= 6'h0;
                seen_q  <= 1'b1;
                phase_q <= realign ? 4'h0 : cnt_q;
                cons_q  <= (seen_q && age_q == `RFDB_CONSEC_GAP && phase_q == cnt_q)
                           ? cons_q + 3'h1 : 3'h1;
            end
            else if (age_q != 6'h3f)
                age_q <= age_q + 6'h1;
        end
    end

    // ==========================================================
    // 10b/8b decoder
    function automatic logic [5:0] dec6(input logic [5:0] c);
        case (c)
            6'h27, 6'h18: dec6 = 6'h20;  6'h1d, 6'h22: dec6 = 6'h21;
            6'h2d, 6'h12: dec6 = 6'h22;  6'h31:        dec6 = 6'h23;
            6'h35, 6'h0a: dec6 = 6'h24;  6'h29:        dec6 = 6'h25;
            6'h19:        dec6 = 6'h26;  6'h38, 6'h07: dec6 = 6'h27;
            6'h39, 6'h06: dec6 = 6'h28;  6'h25:        dec6 = 6'h29;
            6'h15:        dec6 = 6'h2a;  6'h34:        dec6 = 6'h2b;
            6'h0d:        dec6 = 6'h2c;  6'h2c:        dec6 = 6'h2d;
            6'h1c:        dec6 = 6'h2e;  6'h17, 6'h28: dec6 = 6'h2f;
            6'h1b, 6'h24: dec6 = 6'h30;  6'h23:        dec6 = 6'h31;
            6'h13:        dec6 = 6'h32;  6'h32:        dec6 = 6'h33;
            6'h0b:        dec6 = 6'h34;  6'h2a:        dec6 = 6'h35;
            6'h1a:        dec6 = 6'h36;  6'h3a, 6'h05: dec6 = 6'h37;
            6'h33, 6'h0c: dec6 = 6'h38;  6'h26:        dec6 = 6'h39;
            6'h16:        dec6 = 6'h3a;  6'h36, 6'h09: dec6 = 6'h3b;
            6'h0e:        dec6 = 6'h3c;  6'h2e, 6'h11: dec6 = 6'h3d;
            6'h1e, 6'h21: dec6 = 6'h3e;  6'h2b, 6'h14: dec6 = 6'h3f;
            6'h0f, 6'h30: dec6 = 6'h3c;
            default:      dec6 = 6'h00;
        endcase
    endfunction

    function automatic logic [3:0] dec4(input logic [3:0] c);
        case (c)
            4'hb, 4'h4: dec4 = 4'h8;  4'h9:      dec4 = 4'h9;
            4'h5:       dec4 = 4'ha;  4'hc, 4'h3: dec4 = 4'hb;
            4'hd, 4'h2: dec4 = 4'hc;  4'ha:      dec4 = 4'hd;
            4'h6:       dec4 = 4'he;  4'he, 4'h1, 4'h7, 4'h8: dec4 = 4'hf;
            default:    dec4 = 4'h0;
        endcase
    endfunction

    logic [5:0] d6;
    logic [3:0] d4;
    logic [7:0] byte_v;
    logic       is_k, ok;
    assign d6     = dec6(sh_n[9:4]);
    assign d4     = dec4(sh_n[3:0]);
    assign ok     = d6[5] && d4[3];
    assign is_k   = (sh_n[9:4] == 6'h0f) || (sh_n[9:4] == 6'h30)
                    || ((sh_n[3:0] == 4'h7 || sh_n[3:0] == 4'h8) && d6[4:0] > 5'h16
                        && d6[4:0] != 5'h18 && d6[4:0] != 5'h19 && d6[4:0] != 5'h1a
                        && d6[4:0] != 5'h1c && d6[4:0] != 5'h1f);
    // [RULE11] Data identical in both maps, specials differ
    assign byte_v = (is_k && dmode == `RFDB_LVL_HIGH)
                    ? ({d4[2:0], d6[4:0]} ^ `RFDB_ALT_K_XOR) : {d4[2:0], d6[4:0]};

    // ==========================================================
    // Self-test enable latch and pattern checker
    // [RULE13] [RULE14] Transparent while latch enable high, reset to disabled
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
            bist_n_q <= 1'b1;
        else if (bist_reg_q[`RFDB_BIST_LE])
            bist_n_q <= bist_reg_q[`RFDB_BIST_CHEN];
    end

    // [RULE15] 511-state sequence, x^9 + x^5 + 1
    logic [8:0] lfsr_q;
    logic [4:0] wsync_q, bal_q;
    logic       loop_err_q, exp_start;
    logic [9:0] exp_c;
    assign exp_start = (lfsr_q == `RFDB_LFSR_SEED);
    assign exp_c = exp_start ? `RFDB_START_CHAR : {lfsr_q, lfsr_q[8] ^ lfsr_q[4]};

    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n || bist_n_q)
        begin
            bst_q      <= RFDB_B_OFF;
            lfsr_q     <= `RFDB_LFSR_SEED;
            wsync_q    <= 5'h0;
            bal_q      <= 5'h0;
            loop_err_q <= 1'b0;
        end
        else if (bst_q == RFDB_B_OFF)
        begin
            // [RULE17] Preset to start code when self-test is enabled
            bst_q  <= RFDB_B_SEARCH;
            lfsr_q <= `RFDB_LFSR_SEED;
        end
        else if (emit)
        begin
            case (bst_q)
                RFDB_B_SEARCH:
                begin
                    // [RULE16] Word sync must precede the start when clock select not mid
                    if (det && wsync_q != `RFDB_WSYNC_LEN)
                        wsync_q <= wsync_q + 5'h1;
                    if (sh_n == `RFDB_START_CHAR
                        && (cksel == `RFDB_LVL_MID || wsync_q == `RFDB_WSYNC_LEN))
                    begin
                        bst_q      <= RFDB_B_RUN;
                        lfsr_q     <= {lfsr_q[7:0], lfsr_q[8] ^ lfsr_q[4]};
                        bal_q      <= 5'h0;
                        loop_err_q <= 1'b0;
                    end
                end
                RFDB_B_RUN:
                begin
                    // [RULE18] Compare every character against the local sequence
                    lfsr_q <= {lfsr_q[7:0], lfsr_q[8] ^ lfsr_q[4]};
                    if (sh_n != exp_c)
                    begin
                        bal_q      <= bal_q + 5'h1;
                        loop_err_q <= 1'b1;
                    end
                    else if (bal_q != 5'h0)
                        bal_q <= bal_q - 5'h1;
                    // [RULE21] Abort and hunt for the start again
                    if (sh_n != exp_c && bal_q + 5'h1 >= `RFDB_ABORT_BAL)
                    begin
                        bst_q   <= RFDB_B_SEARCH;
                        lfsr_q  <= `RFDB_LFSR_SEED;
                        wsync_q <= 5'h0;
                    end
                    if (exp_start)
                        loop_err_q <= 1'b0;
                end
                default: bst_q <= RFDB_B_OFF;
            endcase
        end
    end

    // ==========================================================
    // Output register
    rfdb_char_t nxt;
    always_comb
    begin
        nxt.data = {2'h0, byte_v};
        if (dmode == `RFDB_LVL_LOW)
            nxt.data = sh_n;
        // [RULE20] Self-test status ignores decoder mode
        if (bst_q != RFDB_B_OFF)
        begin
            if (bst_q != RFDB_B_RUN)
                nxt.status = `RFDB_ST_WAIT;
            // [RULE19] Loop end marker, expected violations never flagged
            else if (exp_start)
                nxt.status = loop_err_q ? `RFDB_ST_LOOP_ERR : `RFDB_ST_LOOP_OK;
            else if (sh_n != exp_c)
                nxt.status = `RFDB_ST_MISMATCH;
            else
                nxt.status = `RFDB_ST_DATA;
        end
        // [RULE25] Realigned or stretched character reports invalid
        else if (realign || last_q != `RFDB_CHAR_LAST || (dmode != `RFDB_LVL_LOW && !ok))
            nxt.status = `RFDB_ST_INVALID;
        else if (dmode != `RFDB_LVL_LOW && det)
            nxt.status = `RFDB_ST_FRAMING;
        // [RULE9] Data versus special status
        else if (dmode != `RFDB_LVL_LOW && is_k)
            nxt.status = `RFDB_ST_SPECIAL;
        else
            nxt.status = `RFDB_ST_DATA;
        // [RULE12] Odd parity over the delivered character; [RULE10] raw in bypass
        nxt.parity = ~^nxt.data;
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
        begin
            out_q         <= '0;
            o_char_strobe <= 1'b0;
        end
        else
        begin
            o_char_strobe <= emit;
            if (emit)
                out_q <= nxt;
        end
    end
    assign o_rx_char   = out_q.data;
    assign o_rx_status = out_q.status;
    assign o_rx_parity = out_q.parity;

    // ==========================================================
    // Checks
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);

    chk_fr_off_hold: assert property ( // [RULE1]
        (tick && !fr_en && !at_bnd) |=> (cnt_q == $past(cnt_q) + 4'h1))
        else $error("Boundary moved while framer disabled");
    chk_stretch_limit: assert property ( // [RULE4]
        last_q >= `RFDB_CHAR_LAST && last_q <= `RFDB_CHAR_LAST + `RFDB_MAX_STRETCH)
        else $error("Character stretched beyond two bits");
    chk_mid_realign: assert property ( // [RULE6]
        (realign && fmode == `RFDB_LVL_MID) |-> (seen_q && age_q < `RFDB_SPAN_BITS))
        else $error("Mid framer moved without confirmation");
    chk_data_status: assert property ( // [RULE9]
        (emit && bst_q == RFDB_B_OFF && dmode != `RFDB_LVL_LOW && ok && !is_k && !det
         && !realign && last_q == `RFDB_CHAR_LAST) |=> (o_rx_status == `RFDB_ST_DATA
                                                       && o_char_strobe))
        else $error("Valid data not reported as 000");
    chk_odd_parity: assert property ( // [RULE12]
        o_char_strobe |-> ^{o_rx_char, o_rx_parity})
        else $error("Parity is not odd");
    chk_latch_hold: assert property ( // [RULE13]
        (!bist_reg_q[`RFDB_BIST_LE] && !$past(bist_reg_q[`RFDB_BIST_LE])) |-> $stable(bist_n_q))
        else $error("Self-test latch changed while closed");
    chk_reset_disable: assert property ( // [RULE14]
        @(posedge i_sys_clk) !i_rst_n |=> (bist_n_q && bst_q == RFDB_B_OFF))
        else $error("Self-test not disabled after reset");
    chk_start_preset: assert property ( // [RULE17]
        (bst_q == RFDB_B_OFF && !bist_n_q) |=> (lfsr_q == `RFDB_LFSR_SEED
                                               && bst_q == RFDB_B_SEARCH))
        else $error("Shift register not preset to start");
    chk_abort_search: assert property ( // [RULE21]
        (emit && bst_q == RFDB_B_RUN && sh_n != exp_c && bal_q == `RFDB_ABORT_BAL - 5'h1
         && !bist_n_q) |=> (bst_q == RFDB_B_SEARCH))
        else $error("Checker did not abort");

    cov_realign: cover property (realign);
    cov_bist_run: cover property (bst_q == RFDB_B_SEARCH ##[1:1000] bst_q == RFDB_B_RUN);
    cov_ll_stretch: cover property (emit && last_q == `RFDB_CHAR_LAST + `RFDB_MAX_STRETCH);
endmodule

`default_nettype wire

// file: bench/rfdb_tx_model.sv
// Serial transmitter model driving the link clock and data line
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Transmitter model
module rfdb_tx_model
(
    output logic o_link_clk,
    output logic o_bit
);
    initial
    begin
        o_link_clk = 1'b0;
        o_bit      = 1'b0;
    end
    // Sends n bits of v, first bit is v[n-1]; clock idles low between calls
    task automatic send(input logic [9:0] v, input int n);
        for (int i = n - 1; i >= 0; i--)
        begin
            o_bit = v[i];
            #62.5;
            o_link_clk = 1'b1;
            #62.5;
            o_link_clk = 1'b0;
        end
        // Released line is inverted so a stale bit never passes as data
        o_bit = ~o_bit;
    endtask
endmodule
`default_nettype wire

// file: bench/rfdb_top_test.sv
// Self-checking testbench for the receive framer and decoder block
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Testbench
module rfdb_top_test
    import rfdb_pkg::*;
;
    logic        sys_clk = 1'b0;
    logic        rst_n   = 1'b0;
    logic        hsel    = 1'b0;
    logic [1:0]  htrans  = 2'h0;
    logic [7:0]  haddr   = 8'h00;
    logic        hwrite  = 1'b0;
    logic [2:0]  hsize   = 3'h2;
    logic [31:0] hwdata  = 32'h0;
    wire logic [31:0] hrdata;
    wire logic        hreadyout;
    wire logic        link_clk;
    wire logic        rx_bit;
    wire logic [9:0]  rx_char;
    wire logic [2:0]  rx_status;
    wire logic        rx_parity;
    wire logic        char_strobe;
    logic [31:0] rd_smp;
    logic        rdy_smp;
    logic [9:0]  seen_q[$];
    logic [2:0]  st_q[$];
    int          failures = 0;
    int          checked  = 0;

    always #5 sys_clk = ~sys_clk;

    rfdb_tx_model u_tx (.o_link_clk(link_clk), .o_bit(rx_bit));

    rfdb_top u_dut (.i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_link_clk(link_clk),
        .i_rx_bit(rx_bit), .i_hsel(hsel), .i_htrans(htrans), .i_haddr(haddr),
        .i_hwrite(hwrite), .i_hsize(hsize), .i_hready(hreadyout), .i_hwdata(hwdata),
        .o_hrdata(hrdata), .o_hreadyout(hreadyout), .o_hresp(), .o_rx_char(rx_char),
        .o_rx_status(rx_status), .o_rx_parity(rx_parity), .o_char_strobe(char_strobe));

    task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
        checked++;
        if (s !== e)
        begin
            failures++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic final_report();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Edge values are sampled so reads never race the slave's updates
    always @(posedge sys_clk)
    begin
        rd_smp  <= hrdata;
        rdy_smp <= hreadyout;
        if (char_strobe === 1'b1)
        begin
            seen_q.push_back(rx_char);
            st_q.push_back(rx_status);
        end
    end

    always @(posedge sys_clk)
        if (char_strobe === 1'b1)
            cmp("parity", 32'h1, {31'h0, ^{rx_char, rx_parity}});

    task automatic wait_rdy();
        int k;
        for (k = 0; k < 50; k++)
        begin
            @(posedge sys_clk);
            #1;
            if (rdy_smp === 1'b1)
                break;
        end
        if (k == 50)
        begin
            failures++;
            final_report();
        end
    endtask

    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= w;
        htrans <= 2'h2;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        r = rd_smp;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        ahb(1'b1, a, d, r);
    endtask

    task automatic rd_cmp(input string n, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        ahb(1'b0, a, 32'h0, r);
        cmp(n, e, r);
    endtask

    task automatic t_regs();
        rd_cmp("ctrl", 8'h00, 32'h0aa);
        rd_cmp("bist", 8'h04, 32'h6);
        wr(8'h0c, 32'hffff);
        rd_cmp("unmapped", 8'h0c, 32'h0);
        // Framer stays multi-byte while self-test is on
        // No alternate framer here, so no framing is owed first
        wr(8'h04, 32'h1);
        wr(8'h04, 32'h0);
        wr(8'h04, 32'h2);
        rd_cmp("latch_held", 8'h04, 32'h2);
        wr(8'h04, 32'h3);
        wr(8'h04, 32'h2);
        rd_cmp("latch_off", 8'h04, 32'h6);
        $display("test regs done");
    endtask

    task automatic get_chars(input int n);
        int k;
        for (k = 0; k < 400 && seen_q.size() < n; k++)
            @(posedge sys_clk);
        if (k == 400)
        begin
            failures++;
            final_report();
        end
    endtask

    // Entries: control word, sent char, expected char, expected status
    task automatic t_decode();
        logic [31:0] tb[6][4] = '{'{32'h8a, 10'h274, 10'h274, 3'h0},
            '{32'h8a, 10'h3c1, 10'h3c1, 3'h0}, '{32'haa, 10'h274, 10'h000, 3'h0},
            '{32'haa, 10'h0f4, 10'h01c, 3'h1}, '{32'hca, 10'h0f4, 10'h09c, 3'h1},
            '{32'hca, 10'h274, 10'h000, 3'h0}};
        for (int i = 0; i < 6; i++)
        begin
            wr(8'h00, tb[i][0]);
            seen_q.delete();
            st_q.delete();
            u_tx.send(tb[i][1][9:0], 10);
            get_chars(1);
            cmp("rx_char", tb[i][2], {22'h0, seen_q[0]});
            cmp("rx_status", tb[i][3], {29'h0, st_q[0]});
        end
        $display("test decode done");
    endtask

    // Shifts the stream by three bits, then offers framing characters
    task automatic frame_try(input logic [31:0] c, input int nk, input int nf, input logic ok);
        logic fnd;
        logic inv;
        wr(8'h00, c);
        seen_q.delete();
        st_q.delete();
        u_tx.send(10'h005, 3);
        repeat (nk) u_tx.send(10'h0fa, 10);
        repeat (nf) u_tx.send(10'h2aa, 10);
        u_tx.send(10'h274, 10);
        u_tx.send(10'h155, 10);
        // Strobe follows the last bit within a few cycles
        repeat (20) @(posedge sys_clk);
        fnd = seen_q.size() > 1 && seen_q[$-1] === 10'h274 && seen_q[$] === 10'h155;
        inv = 1'b0;
        foreach (st_q[i])
            inv |= st_q[i] === 3'h6;
        cmp("aligned", {31'h0, ok}, {31'h0, fnd});
        if (ok)
            cmp("realign_status", 32'h1, {31'h0, inv});
        $display("test framer %h done", c);
    endtask

    initial
    begin
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        #1;
        t_regs();
        t_decode();
        frame_try(32'h8a, 4, 0, 1'b0);
        frame_try(32'h8b, 2, 0, 1'b1);
        frame_try(32'h8d, 3, 0, 1'b0);
        frame_try(32'h8d, 4, 0, 1'b1);
        frame_try(32'h93, 2, 0, 1'b1);
        frame_try(32'h89, 1, 9, 1'b1);
        final_report();
    end
endmodule
`default_nettype wire
